// file: dv/sitc_bus_peer.sv
// partner model: other bus agents driving the id lines
module sitc_bus_peer #(
    parameter int HOLD = 12
) (
    // clock
    input wire logic clk,
    // command from bench
    input wire logic go,
    input wire logic [15:0] ids,
    // id lines towards the block
    output logic [15:0] bus_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] bus_r = 16'h0000;
    int cnt = 0;
    assign bus_data = bus_r;
    // assert ids for a fixed span, then let terminators deassert
    always @(posedge clk) begin
        if (go) begin
            bus_r <= ids;
            cnt <= HOLD;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else begin
            bus_r <= 16'h0000;
            cnt <= 0;
        end
    end
endmodule : sitc_bus_peer

// file: dv/sitc_regs_sva.sv
// checker: status, mode and pad enable relations of the register group
module sitc_regs_sva #(
    parameter int OFS_W = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire sitc_pkg::sitc_req_t req,
    input wire logic [7:0] rdata,
    // core inputs
    input wire logic sel_enable,
    input wire logic [3:0] offset_max,
    input wire sitc_pkg::sitc_pad_t core_oe,
    input wire sitc_pkg::sitc_pad_t latch_oe,
    // outputs watched
    input wire sitc_pkg::sitc_pad_t pad_oe,
    input wire sitc_pkg::sitc_clk_src_t clk_src,
    input wire logic doubler_power,
    input wire logic input_low_power,
    input wire logic loopback_mode,
    input wire logic always_wide,
    input wire logic [OFS_W-1:0] offset_count
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==================== shadow of control bytes
    logic [7:0] iso_r;
    logic [7:0] diag_r;
    // follow writes to clock/isolation and diag bytes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            iso_r <= 8'h00;
            diag_r <= 8'h00;
        end else if (req.wr) begin
            if (req.addr == 10'h134) iso_r <= req.wdata;
            if (req.addr == 10'h138) diag_r <= req.wdata;
        end
    end

    // ==================== properties
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_stat_rd;
        req.rd && req.addr == 10'h130;
    endsequence
    sequence s_rof_wr;
        req.wr && req.addr == 10'h138 && req.wdata[6];
    endsequence
    property p_ofs_zero;
        s_stat_rd |=> rdata[1] == ($past(offset_count) == '0);
    endproperty
    a_ofs_zero: assert property (p_ofs_zero)
        else $error("offset zero status wrong");
    property p_ofs_max;
        s_stat_rd |=> rdata[0] ==
            ($past(offset_count) == OFS_W'($past(offset_max)));
    endproperty
    a_ofs_max: assert property (p_ofs_max)
        else $error("offset maximum status wrong");
    property p_sel_ready;
        s_stat_rd |=> rdata[3] ==
            ($past(sel_enable) && !$past(iso_r[6]));
    endproperty
    a_sel_ready: assert property (p_sel_ready)
        else $error("selection ready status wrong");
    property p_ofs_clear;
        s_rof_wr |-> ##2 offset_count == '0;
    endproperty
    a_ofs_clear: assert property (p_ofs_clear)
        else $error("offset not cleared");
    property p_hiz;
        diag_r[3] |-> pad_oe == '0;
    endproperty
    a_hiz: assert property (p_hiz)
        else $error("driver enabled in high impedance");
    property p_diff;
        diag_r[5] |-> {pad_oe.bsy, pad_oe.sel, pad_oe.rst} == 3'h0;
    endproperty
    a_diff: assert property (p_diff)
        else $error("control pad driven in differential");
    property p_ctl_en;
        !diag_r[3] && !diag_r[5] |->
            pad_oe == (diag_r[7] ? latch_oe : core_oe);
    endproperty
    a_ctl_en: assert property (p_ctl_en)
        else $error("pad enable source wrong");
    property p_pci;
        iso_r[7] |-> clk_src == sitc_pkg::SITC_CLK_PCI;
    endproperty
    a_pci: assert property (p_pci)
        else $error("pci clock not selected");
    property p_dbl_pwr;
        !iso_r[3] |-> !doubler_power;
    endproperty
    a_dbl_pwr: assert property (p_dbl_pwr)
        else $error("doubler powered while disabled");
    property p_iso;
        input_low_power == iso_r[6];
    endproperty
    a_iso: assert property (p_iso)
        else $error("isolation output wrong");
    property p_modes;
        {loopback_mode, always_wide} == {diag_r[4], diag_r[2]};
    endproperty
    a_modes: assert property (p_modes)
        else $error("loopback or wide mode wrong");
endmodule : sitc_regs_sva

bind sitc_regs sitc_regs_sva #(.OFS_W(OFS_W)) u_sitc_regs_sva (
    .clk(clk), .reset_n(reset_n), .req(req), .rdata(rdata),
    .sel_enable(sel_enable), .offset_max(offset_max),
    .core_oe(core_oe), .latch_oe(latch_oe), .pad_oe(pad_oe),
    .clk_src(clk_src), .doubler_power(doubler_power),
    .input_low_power(input_low_power), .loopback_mode(loopback_mode),
    .always_wide(always_wide), .offset_count(offset_count)
);

// file: dv/sitc_regs_tb.sv
// testbench: register access, modes, selection, offset and timer
module sitc_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 4;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    sitc_pkg::sitc_req_t req = '0;
    logic [7:0] rdata;
    logic [15:0] bus_in;
    logic [15:0] core_bus;
    logic arb_act = 1'h0;
    logic sel_ph = 1'h0;
    logic sel_en = 1'h0;
    logic run = 1'h0;
    logic inc = 1'h0;
    logic dec = 1'h0;
    logic peer_on = 1'h0;
    logic halt = 1'h0;
    logic [3:0] ofs_max = 4'h3;
    sitc_pkg::sitc_pad_t core_oe = '1;
    sitc_pkg::sitc_pad_t latch_oe = 25'h0a5a5a5;
    sitc_pkg::sitc_pad_t pad_oe;
    sitc_pkg::sitc_pad_t e;
    sitc_pkg::sitc_clk_src_t clk_src;
    logic gto, rsp, sel_rsp, clk_run, dbl_pwr, low_pwr, loop_m, wide_m;
    logic [3:0] arb_id;
    logic [4:0] ofs;
    logic go = 1'h0;
    logic [15:0] ids = 16'h0000;
    logic [7:0] v;
    logic [7:0] dg [6] = '{8'h00, 8'h08, 8'h20, 8'h80, 8'ha0, 8'h94};
    logic [15:0] sb [3] = '{16'h8140, 16'h0041, 16'h0040};
    logic [3:0] si [3] = '{4'hf, 4'h0, 4'h0};
    logic sr [3] = '{1'h1, 1'h1, 1'h0};
    int mismatches = 0;
    int n_tests = 0;

    always #5 clk = ~clk;

    sitc_regs #(.TICK_CYCLES(T), .OFS_W(5)) u_sitc_regs (
        .clk(clk), .reset_n(reset_n), .req(req), .rdata(rdata),
        .bus_data_in(bus_in), .bus_data_core(core_bus),
        .arb_active(arb_act), .sel_phase(sel_ph), .sel_enable(sel_en),
        .timer_run(run), .offset_inc(inc), .offset_dec(dec),
        .offset_max(ofs_max), .peer_doubler_on(peer_on),
        .halt_clock(halt), .core_oe(core_oe), .latch_oe(latch_oe),
        .pad_oe(pad_oe), .general_timeout(gto), .sel_respond(sel_rsp),
        .arb_id(arb_id), .clk_src(clk_src), .doubler_power(dbl_pwr),
        .clock_run(clk_run), .input_low_power(low_pwr),
        .loopback_mode(loop_m), .always_wide(wide_m), .offset_count(ofs)
    );
    sitc_bus_peer u_sitc_bus_peer (
        .clk(clk), .go(go), .ids(ids), .bus_data(bus_in)
    );

    // ==================== tasks
    task automatic chk(input string n, input logic [31:0] x,
                       input logic [31:0] g);
        n_tests++;
        if (g !== x) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", n, x, g);
        end
    endtask : chk
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'h1;
        @(posedge clk);
        req.wr <= 1'h0;
        #1;
    endtask : wr
    task automatic rd(input logic [9:0] a);
        @(posedge clk);
        req.addr <= a;
        req.rd <= 1'h1;
        @(posedge clk);
        req.rd <= 1'h0;
        #1 v = rdata;
    endtask : rd
    // peer drives ids, then status is read while held
    task automatic probe(input logic [15:0] d);
        @(posedge clk);
        ids <= d;
        go <= 1'h1;
        @(posedge clk);
        go <= 1'h0;
        repeat (8) @(posedge clk);
        #1 rsp = sel_rsp;
        rd(10'h130);
    endtask : probe
    task automatic tmr(input logic [7:0] p);
        int lim;
        int n;
        int hits;
        int first;
        lim = (p[3:0] == 4'h0) ? 0 : (T << (p[3:0] - 1)) * (p[5] ? 16 : 1);
        hits = 0;
        first = 0;
        // zero period before a new one
        wr(10'h124, 8'h00);
        wr(10'h124, p);
        @(posedge clk);
        run <= 1'h1;
        for (n = 1; n <= lim * 2 + 20; n++) begin
            @(posedge clk);
            #1 if (gto === 1'h1) hits++;
            if (gto === 1'h1 && first == 0) first = n;
        end
        run <= 1'h0;
        chk("timeouts", (lim > 0) ? 1 : 0, hits);
        if (lim > 0) chk("timer span", 1, first >= lim - 1 && first <= lim + 4);
    endtask : tmr
    task automatic final_report;
        $display("checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    // ==================== watchdog
    initial begin
        #300us;
        mismatches++;
        final_report();
    end

    // ==================== main sequence
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'h1;
        rd(10'h130);
        chk("status reset", 8'h02, v);
        chk("chip id", 4'h7, arb_id);
        wr(10'h130, 8'hff);
        rd(10'h130);
        chk("status ro", 8'h02, v);
        rd(10'h131);
        chk("unmapped", 8'h00, v);
        wr(10'h128, 8'h01);
        wr(10'h12c, 8'h81);
        rd(10'h12c);
        chk("resp high", 8'h81, v);
        wr(10'h134, 8'hff);
        rd(10'h134);
        chk("clk iso rw", 8'hcc, v);
        for (int i = 0; i < 6; i++) begin
            wr(10'h138, dg[i]);
            e = dg[i][3] ? '0 : (dg[i][7] ? latch_oe : core_oe);
            if (dg[i][5]) {e.bsy, e.sel, e.rst} = 3'h0;
            chk("pad enables", e, pad_oe);
            chk("loopback", dg[i][4], loop_m);
            chk("wide", dg[i][2], wide_m);
        end
        wr(10'h138, 8'h00);
        wr(10'h134, 8'h80);
        chk("pci clock", sitc_pkg::SITC_CLK_PCI, clk_src);
        wr(10'h134, 8'h00);
        chk("pin clock", sitc_pkg::SITC_CLK_EXT, clk_src);
        chk("doubler off", 1'h0, dbl_pwr);
        wr(10'h134, 8'h08);
        chk("doubler on", 1'h1, dbl_pwr);
        repeat (2000) @(posedge clk);
        halt <= 1'h1;
        wr(10'h134, 8'h0c);
        chk("doubler clock", sitc_pkg::SITC_CLK_DBL, clk_src);
        chk("clock halted", 1'h0, clk_run);
        @(posedge clk);
        halt <= 1'h0;
        peer_on <= 1'h1;
        wr(10'h134, 8'h04);
        chk("peer doubler", sitc_pkg::SITC_CLK_DBL, clk_src);
        peer_on <= 1'h0;
        #1 chk("no doubler", sitc_pkg::SITC_CLK_EXT, clk_src);
        sel_en <= 1'h1;
        wr(10'h134, 8'h40);
        probe(16'h00ff);
        chk("ready isolated", 1'h0, v[3]);
        chk("isolated bus", 16'h0000, core_bus);
        wr(10'h134, 8'h00);
        sel_ph <= 1'h1;
        for (int i = 0; i < 3; i++) begin
            probe(sb[i]);
            chk("respond", sr[i], rsp);
            chk("selected as", si[i], v[7:4]);
            repeat (8) @(posedge clk);
        end
        sel_ph <= 1'h0;
        arb_act <= 1'h1;
        probe(16'h0088);
        chk("arb won", 1'h1, v[2]);
        repeat (8) @(posedge clk);
        probe(16'h0008);
        chk("arb lost", 1'h0, v[2]);
        arb_act <= 1'h0;
        inc <= 1'h1;
        repeat (3) @(posedge clk);
        inc <= 1'h0;
        rd(10'h130);
        chk("offset at max", 2'h1, v[1:0]);
        dec <= 1'h1;
        inc <= 1'h1;
        @(posedge clk);
        {inc, dec} <= 2'h0;
        wr(10'h138, 8'h40);
        rd(10'h138);
        chk("offset reset clear", 8'h00, v);
        rd(10'h130);
        chk("offset zero", 2'h2, v[1:0]);
        tmr(8'h01);
        tmr(8'h03);
        tmr(8'h21);
        tmr(8'h00);
        final_report();
    end
endmodule : sitc_regs_tb

// file: rtl/sitc_pkg.sv
// package: register map, field layout, reset values and timing counts
package sitc_pkg;

    // ==================== register indices (byte address = 4 * index)
    localparam logic [7:0] IDX_CHIP_ID = 8'h40;
    localparam logic [7:0] IDX_TIMER_ONE = 8'h49;
    localparam logic [7:0] IDX_RESP_LOW = 8'h4a;
    localparam logic [7:0] IDX_RESP_HIGH = 8'h4b;
    localparam logic [7:0] IDX_TEST_STATUS = 8'h4c;
    localparam logic [7:0] IDX_CLK_ISO = 8'h4d;
    localparam logic [7:0] IDX_DIAG = 8'h4e;
    localparam int ADDR_W = 10;

    // ==================== timer_one_register fields
    localparam int GEN_PERIOD_LSB = 0;
    localparam int GEN_SCALE_BIT = 5;
    localparam logic [7:0] TIMER_ONE_MASK = 8'h2f;

    // ==================== bus_test_status fields
    localparam int SEL_AS_LSB = 4;
    localparam int SEL_READY_BIT = 3;
    localparam int ARB_WON_BIT = 2;
    localparam int OFS_ZERO_BIT = 1;
    localparam int OFS_MAX_BIT = 0;

    // ==================== clock_isolation_control fields
    localparam int PCI_CLK_BIT = 7;
    localparam int ISO_BIT = 6;
    localparam int DBL_EN_BIT = 3;
    localparam int DBL_SEL_BIT = 2;
    localparam logic [7:0] CLK_ISO_MASK = 8'hcc;

    // ==================== bus_diag_control fields
    localparam int CTL_EN_BIT = 7;
    localparam int OFS_RST_BIT = 6;
    localparam int DIFF_BIT = 5;
    localparam int LOOP_BIT = 4;
    localparam int HIZ_BIT = 3;
    localparam int WIDE_BIT = 2;

    // ==================== reset values and timer scale factor
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [3:0] CHIP_ID_RST = 4'h7;
    localparam int GEN_SCALE = 16;

    // ==================== timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TIMER_BASE_NS = 100000;
    localparam int TIMER_BASE_CYC =
        (TIMER_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==================== internal scsi clock source
    typedef enum logic [1:0] {
        SITC_CLK_EXT = 2'b00,
        SITC_CLK_DBL = 2'b01,
        SITC_CLK_PCI = 2'b11
    } sitc_clk_src_t;

    // ==================== register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sitc_req_t;

    // ==================== pad enables towards the bus
    typedef struct packed {
        logic bsy;
        logic sel;
        logic rst;
        logic [5:0] ctl;
        logic [15:0] data;
    } sitc_pad_t;

endpackage : sitc_pkg

// file: rtl/sitc_regs.sv
// module: test, id and clock control register group of one bus function
// Operation
// - general timer times enable-to-disable, flags timeout
// - two response id bytes form 16-bit mask
// - arbitration uses only the chip id
// - responding id stored encoded in bits 7-4
// - selection-ready bit set ignoring settle delay
// - arbitration-won when own id highest asserted
// - live offset-zero status bit
// - live offset-maximum versus programmed maximum
// - clock-source bit selects pci clock
// - isolation bit gates bus inputs, low power
// - doubler powered only when enabled
// - doubler-select picks doubler or clock pin
// - control-enable gives software all line drives
// - offset-reset clears offset, self-clears
// - differential bit tristates busy, select, reset
// - loopback makes core initiator and target
// - high-impedance bit floats all open-drain drivers
// - always-wide forces 16-bit transfer phases
// - scale-factor bit lengthens timer by 16
module sitc_regs #(
    parameter int TICK_CYCLES = sitc_pkg::TIMER_BASE_CYC,
    parameter int OFS_W = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire sitc_pkg::sitc_req_t req,
    output logic [7:0] rdata,
    // bus inputs from pins
    input wire logic [15:0] bus_data_in,
    output logic [15:0] bus_data_core,
    // core status and events
    input wire logic arb_active,
    input wire logic sel_phase,
    input wire logic sel_enable,
    input wire logic timer_run,
    input wire logic offset_inc,
    input wire logic offset_dec,
    input wire logic [3:0] offset_max,
    input wire logic peer_doubler_on,
    input wire logic halt_clock,
    // driver requests from core and bit-level latches
    input wire sitc_pkg::sitc_pad_t core_oe,
    input wire sitc_pkg::sitc_pad_t latch_oe,
    output sitc_pkg::sitc_pad_t pad_oe,
    // timer and selection results
    output logic general_timeout,
    output logic sel_respond,
    output logic [3:0] arb_id,
    // mode outputs
    output sitc_pkg::sitc_clk_src_t clk_src,
    output logic doubler_power,
    output logic clock_run,
    output logic input_low_power,
    output logic loopback_mode,
    output logic always_wide,
    output logic [OFS_W-1:0] offset_count
);

    // ==================== helpers
    // rank of an id in arbitration priority: 7 highest, 8 lowest
    function automatic logic [3:0] sitc_rank(input logic [3:0] id);
        sitc_rank = id[3] ? {1'b0, id[2:0]} : {1'b1, id[2:0]};
    endfunction : sitc_rank

    // highest-priority id set in a vector
    function automatic logic [3:0] sitc_best(input logic [15:0] v);
        logic [3:0] best;
        best = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (v[i] && (!v[best] || sitc_rank(4'(i)) > sitc_rank(best))) begin
                best = 4'(i);
            end
        end
        sitc_best = best;
    endfunction : sitc_best

    // ==================== registers
    logic [7:0] resp_low_r;
    logic [7:0] resp_high_r;
    logic [7:0] clk_iso_r;
    logic [7:0] diag_r;
    logic [7:0] diag_nxt;
    logic [7:0] timer_one_r;
    logic [3:0] chip_id_r;
    logic [3:0] sel_as_r;
    logic [3:0] sel_as_nxt;
    logic [7:0] rdata_r;
    logic [OFS_W-1:0] ofs_r;
    logic [OFS_W-1:0] ofs_nxt;
    logic [15:0] tick_r;
    logic [15:0] tick_nxt;
    logic [18:0] gen_cnt_r;
    logic [18:0] gen_cnt_nxt;
    logic gen_done_r;
    logic gen_done_nxt;
    logic [15:0] sync1_r;
    logic [15:0] sync2_r;
    logic [15:0] sync3_r;
    logic [15:0] bus_stable_r;

    // ==================== address decode
    localparam int ADDR_W = sitc_pkg::ADDR_W;
    wire [7:0] idx = req.addr[ADDR_W-1:2];
    wire aligned = req.addr[1:0] == 2'b00;
    wire hit_chip = aligned && idx == sitc_pkg::IDX_CHIP_ID;
    wire hit_timer = aligned && idx == sitc_pkg::IDX_TIMER_ONE;
    wire hit_low = aligned && idx == sitc_pkg::IDX_RESP_LOW;
    wire hit_high = aligned && idx == sitc_pkg::IDX_RESP_HIGH;
    wire hit_stat = aligned && idx == sitc_pkg::IDX_TEST_STATUS;
    wire hit_clk = aligned && idx == sitc_pkg::IDX_CLK_ISO;
    wire hit_diag = aligned && idx == sitc_pkg::IDX_DIAG;

    // ==================== pin synchroniser, three stages per bit
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_sync
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                    sync3_r[gi] <= 1'b0;
                    bus_stable_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= bus_data_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    sync3_r[gi] <= sync2_r[gi];
                    // change counts once stages two and three agree
                    if (sync2_r[gi] == sync3_r[gi]) begin
                        bus_stable_r[gi] <= sync3_r[gi];
                    end
                end
            end
        end
    endgenerate

    // ==================== mode decode
    wire iso_mode = clk_iso_r[sitc_pkg::ISO_BIT];
    wire pci_clk_sel = clk_iso_r[sitc_pkg::PCI_CLK_BIT];
    wire dbl_en = clk_iso_r[sitc_pkg::DBL_EN_BIT];
    wire dbl_sel = clk_iso_r[sitc_pkg::DBL_SEL_BIT];
    wire ctl_en = diag_r[sitc_pkg::CTL_EN_BIT];
    wire diff_mode = diag_r[sitc_pkg::DIFF_BIT];
    wire hiz_mode = diag_r[sitc_pkg::HIZ_BIT];
    wire [3:0] gen_period = timer_one_r[sitc_pkg::GEN_PERIOD_LSB +: 4];
    wire gen_scale = timer_one_r[sitc_pkg::GEN_SCALE_BIT];

    // isolated inputs read as deasserted and stay quiet
    assign bus_data_core = iso_mode ? 16'h0000 : bus_stable_r;
    assign input_low_power = iso_mode;

    // ==================== clock source selection
    // doubler output valid with enable and select in this function, or when the peer has its doubler on
    wire doubler_ok = (dbl_en && dbl_sel) || peer_doubler_on;
    assign doubler_power = dbl_en;
    assign clock_run = !halt_clock;

    // select bit chooses doubler, else the clock pin
    assign clk_src = pci_clk_sel ? sitc_pkg::SITC_CLK_PCI :
        (dbl_sel && doubler_ok) ? sitc_pkg::SITC_CLK_DBL :
        sitc_pkg::SITC_CLK_EXT;

    // ==================== arbitration and selection
    // only the chip id takes part in arbitration
    assign arb_id = chip_id_r;
    wire [3:0] bus_best = sitc_best(bus_data_core);
    // won when own id is the highest asserted
    wire arb_won = arb_active && bus_data_core[chip_id_r] &&
        (bus_best == chip_id_r);

    // high byte carries ids 15-8, low byte ids 7-0
    wire [15:0] resp_mask = {resp_high_r, resp_low_r};
    wire [15:0] sel_match = bus_data_core & resp_mask;
    wire sel_hit = sel_phase && (sel_match != 16'h0000);
    assign sel_respond = sel_hit;

    // ready flag takes no account of the settle delay
    wire sel_ready = sel_enable && !iso_mode;

    assign sel_as_nxt = sel_hit ? sitc_best(sel_match) : sel_as_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_as_r <= 4'h0;
        end else begin
            sel_as_r <= sel_as_nxt;
        end
    end

    // ==================== synchronous offset counter
    // offset reset wins over counting
    wire ofs_clear = diag_r[sitc_pkg::OFS_RST_BIT];
    wire [OFS_W-1:0] ofs_one = OFS_W'(1);
    assign ofs_nxt = ofs_clear ? '0 :
        (offset_inc && !offset_dec) ? ofs_r + ofs_one :
        (offset_dec && !offset_inc && ofs_r != '0) ? ofs_r - ofs_one :
        ofs_r;
    assign offset_count = ofs_r;

    wire ofs_zero = ofs_r == '0;
    wire ofs_max = ofs_r == OFS_W'(offset_max);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ofs_r <= '0;
        end else begin
            ofs_r <= ofs_nxt;
        end
    end

    // ==================== general purpose timer
    // count base ticks while enabled, pulse on expiry
    // scale factor multiplies the limit by 16
    wire [18:0] gen_base = 19'(1) << (gen_period - 4'h1);
    wire [18:0] gen_limit = gen_scale ?
        19'(gen_base * sitc_pkg::GEN_SCALE) : gen_base;
    wire gen_armed = timer_run && gen_period != 4'h0;
    wire tick = tick_r == 16'(TICK_CYCLES - 1);

    // a zero period clears the timer so a new one starts fresh
    always_comb begin
        tick_nxt = tick_r;
        gen_cnt_nxt = gen_cnt_r;
        gen_done_nxt = gen_done_r;
        if (!gen_armed) begin
            tick_nxt = 16'h0000;
            gen_cnt_nxt = 19'h00000;
            gen_done_nxt = 1'b0;
        end else if (!gen_done_r) begin
            tick_nxt = tick ? 16'h0000 : tick_r + 16'h0001;
            if (tick) begin
                gen_cnt_nxt = gen_cnt_r + 19'h00001;
                gen_done_nxt = (gen_cnt_r + 19'h00001) >= gen_limit;
            end
        end
    end
    assign general_timeout = gen_done_nxt && !gen_done_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_r <= 16'h0000;
            gen_cnt_r <= 19'h00000;
            gen_done_r <= 1'b0;
        end else begin
            tick_r <= tick_nxt;
            gen_cnt_r <= gen_cnt_nxt;
            gen_done_r <= gen_done_nxt;
        end
    end

    // ==================== pad drive enables
    // control enable hands every line to the output latches
    sitc_pkg::sitc_pad_t drive_sel;
    assign drive_sel = ctl_en ? latch_oe : core_oe;

    // high impedance floats every open-drain driver
    // differential leaves busy, select and reset as inputs
    always_comb begin
        pad_oe = drive_sel;
        if (diff_mode) begin
            pad_oe.bsy = 1'b0;
            pad_oe.sel = 1'b0;
            pad_oe.rst = 1'b0;
        end
        if (hiz_mode) begin
            pad_oe = '0;
        end
    end

    // loopback runs core as initiator and target
    assign loopback_mode = diag_r[sitc_pkg::LOOP_BIT];
    assign always_wide = diag_r[sitc_pkg::WIDE_BIT];

    // ==================== register writes
    // offset reset bit self-clears after one cycle
    always_comb begin
        diag_nxt = diag_r;
        diag_nxt[sitc_pkg::OFS_RST_BIT] = 1'b0;
        if (req.wr && hit_diag) begin
            diag_nxt = req.wdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            resp_low_r <= sitc_pkg::RST_ZERO;
            resp_high_r <= sitc_pkg::RST_ZERO;
            clk_iso_r <= sitc_pkg::RST_ZERO;
            diag_r <= sitc_pkg::RST_ZERO;
            timer_one_r <= sitc_pkg::RST_ZERO;
            chip_id_r <= sitc_pkg::CHIP_ID_RST;
        end else begin
            diag_r <= diag_nxt;
            if (req.wr && hit_low) begin
                resp_low_r <= req.wdata;
            end
            if (req.wr && hit_high) begin
                resp_high_r <= req.wdata;
            end
            if (req.wr && hit_clk) begin
                clk_iso_r <= req.wdata & sitc_pkg::CLK_ISO_MASK;
            end
            if (req.wr && hit_timer) begin
                timer_one_r <= req.wdata & sitc_pkg::TIMER_ONE_MASK;
            end
            if (req.wr && hit_chip) begin
                chip_id_r <= req.wdata[3:0];
            end
        end
    end

    // ==================== read mux
    // status bits are sampled live at the read
    wire [7:0] stat_val = {sel_as_r, sel_ready, arb_won, ofs_zero, ofs_max};
    wire [7:0] rd_mux = hit_low ? resp_low_r :
        hit_high ? resp_high_r :
        hit_stat ? stat_val :
        hit_clk ? clk_iso_r :
        hit_diag ? diag_r :
        hit_timer ? timer_one_r :
        hit_chip ? {4'h0, chip_id_r} : 8'h00;

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= req.rd ? rd_mux : 8'h00;
        end
    end
    assign rdata = rdata_r;

endmodule : sitc_regs
